// File: hdl/cdio_defines.vh
/*
 * constants for the digital i/o board core: register byte offsets,
 * field positions, reset values and timing figures.
 * assumes inclusion by bare name from the design file.
 */
`ifndef CDIO_DEFINES_VH
`define CDIO_DEFINES_VH
// register byte offsets
`define CDIO_CTRL_ADDR     8'h00
`define CDIO_RESP_ADDR     8'h04
`define CDIO_IRQ_STAT_ADDR 8'h08
`define CDIO_IRQ_CLR_ADDR  8'h0c
`define CDIO_IRQ_EN_ADDR   8'h10
`define CDIO_STATE_ADDR    8'h14
`define CDIO_MTX_LO_ADDR   8'h18
`define CDIO_MTX_HI_ADDR   8'h1c
`define CDIO_DISP_ADDR     8'h20
`define CDIO_HWR_ADDR      8'h24
`define CDIO_HRD_ADDR      8'h28
`define CDIO_LAT_BASE      8'h30
`define CDIO_LAT_LAST      8'h40
// control fields
`define CDIO_CTRL_DEC_EN   0
`define CDIO_CTRL_LAT_CLR  1
`define CDIO_CTRL_INHIBIT  2
`define CDIO_CTRL_CNT_LO   3
`define CDIO_CTRL_CNT_HI   4
`define CDIO_CTRL_RESET    32'h0000_001b
// event bits
`define CDIO_EV_OVLD       0
`define CDIO_EV_ACK_DONE   1
`define CDIO_EV_HOST_WR    2
`define CDIO_EV_MATRIX     3
`define CDIO_NUM_EV        4
`define CDIO_NUM_LATCH     5
// axi responses
`define CDIO_RESP_OKAY     2'b00
`define CDIO_RESP_SLVERR   2'b10
// activity monitor timeout
`define CDIO_CLK_NS        10
`define CDIO_ACT_TIMEOUT_NS 10000000
`define CDIO_ACT_CYCLES    (`CDIO_ACT_TIMEOUT_NS / `CDIO_CLK_NS)
`endif

// File: hdl/cdio_board.v
/*
 * digital i/o board core: host transceiver with board address match,
 * eight-input overload interrupt collector, scan counter and decoder,
 * display nibbles, five latches of eight open-collector drivers, activity monitor,
 * and an axi4-lite register slave with an interrupt output.
 * assumes host pins on or synced to aclk; overload/matrix inputs pass through synchronisers here.
 */
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cdio_defines.vh"
module cdio_board #(
   parameter ACT_CYCLES = `CDIO_ACT_CYCLES
) (
   input  wire        aclk,                 // 100 mhz clock
   input  wire        aresetn,              // sync reset, low
   input  wire        clk_en,               // freezes all state when low
   input  wire [7:0]  s_axi_awaddr,         // write address
   input  wire        s_axi_awvalid,        // write address valid
   output reg         s_axi_awready,        // write address ready
   input  wire [31:0] s_axi_wdata,          // write data
   input  wire [3:0]  s_axi_wstrb,          // write strobes
   input  wire        s_axi_wvalid,         // write data valid
   output reg         s_axi_wready,         // write data ready
   output reg  [1:0]  s_axi_bresp,          // write response
   output reg         s_axi_bvalid,         // write response valid
   input  wire        s_axi_bready,         // write response ready
   input  wire [7:0]  s_axi_araddr,         // read address
   input  wire        s_axi_arvalid,        // read address valid
   output reg         s_axi_arready,        // read address ready
   output reg  [31:0] s_axi_rdata,          // read data
   output reg  [1:0]  s_axi_rresp,          // read response
   output reg         s_axi_rvalid,         // read data valid
   input  wire        s_axi_rready,         // read data ready
   output reg         irq,                  // level interrupt, high
   input  wire [3:0]  host_addr,            // host address bits
   input  wire [3:0]  board_id_jumpers,     // jumper board identity
   input  wire        transfer_direction,   // 1 host->board, 0 board->host
   input  wire        irq_acknowledge_n,    // host acknowledge, low
   input  wire        host_wr_n,            // host write strobe, low
   input  wire        host_rd_n,            // host read strobe, low
   input  wire [7:0]  host_data_i,          // host data bus in
   output reg  [7:0]  host_data_o,          // host data bus out
   output reg  [7:0]  host_data_oe_n,       // low while driving host bus
   output reg         transceiver_enable_n, // low when board selected
   output reg         service_request_n,    // low while overload pending
   input  wire [7:0]  overload_request_n,   // async overload requests
   output reg  [3:0]  scan_select_lines,    // free-running scan count
   output reg  [7:0]  scan_lines_n,         // decoded scan lines, low
   input  wire [7:0]  matrix_return_lines,  // async matrix returns
   output reg  [3:0]  display_nibble_a,     // display nibble a
   output reg  [3:0]  display_nibble_b,     // display nibble b
   output reg  [4:0]  latch_strobe_n,       // latch strobes, low
   output reg  [39:0] driver_oe_n,          // open-collector pulls, low=on
   output reg         activity_indicator    // board activity led
);
   // address receiver enables are wired low on the board
   localparam ADDR_RX_ENABLE_ONE_N = 1'b0;
   localparam ADDR_RX_ENABLE_TWO_N = 1'b0;
   localparam [23:0] ACT_LOAD = ACT_CYCLES;
   reg [31:0] ctrl_q, resp_q, w_data_q;
   reg [`CDIO_NUM_EV-1:0] ev_stat_q, ev_en_q, ev_set;
   reg [7:0]  hwr_q, hrd_q, pend_q, aw_addr_q;
   reg [7:0]  lat_src_q [0:`CDIO_NUM_LATCH-1];
   reg [7:0]  disp_q [0:15];
   reg [7:0]  mtx_q [0:7];
   reg [7:0]  ovl_s1_q, ovl_s2_q, ovl_s3_q, ret_s1_q, ret_s2_q;
   reg [3:0]  cnt_q, w_strb_q;
   reg [2:0]  idx_p1_q, idx_p2_q;
   reg [1:0]  ack_idx_q;
   reg        irq_acknowledge_n_prev_q, wr_prev_q, aw_got_q, w_got_q;
   reg [23:0] act_cnt_q;
   integer    i;
   // address path; receiver always passes since both enables are low
   wire [3:0] addr_rx = (ADDR_RX_ENABLE_ONE_N | ADDR_RX_ENABLE_TWO_N)
                        ? 4'h0 : host_addr;
   wire       match   = (addr_rx == board_id_jumpers);
   wire       sel     = ~transceiver_enable_n;
   wire       irq_acknowledge_n_fall = sel & irq_acknowledge_n_prev_q & ~irq_acknowledge_n;
   wire       wr_fall   = sel & transfer_direction & wr_prev_q & ~host_wr_n;
   wire       rd_act    = sel & ~transfer_direction & ~host_rd_n;
   wire [3:0] cnt_d     = cnt_q + 4'h1;
   wire [1:0] resp_last = ctrl_q[`CDIO_CTRL_CNT_HI:`CDIO_CTRL_CNT_LO];
   wire [7:0] ovl_fall  = ovl_s3_q & ~ovl_s2_q;
   wire [7:0] resp_byte = resp_q[ack_idx_q*8 +: 8];
   wire       do_wr     = aw_got_q & w_got_q & ~s_axi_bvalid;
   wire       trig      = wr_fall | rd_act | irq_acknowledge_n_fall;

   // axi write: address and data taken in either order, answer after both
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `CDIO_RESP_OKAY;
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
      end else if (clk_en) begin
         s_axi_awready <= ~aw_got_q & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_got_q & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q  <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q  <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q <= `CDIO_LAT_LAST && aw_addr_q[1:0] == 2'b00)
                            ? `CDIO_RESP_OKAY : `CDIO_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
         end
      end
   end

   // register writes; low byte lane governs byte-wide fields
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q  <= `CDIO_CTRL_RESET;
         resp_q  <= 32'h0000_0000;
         ev_en_q <= {`CDIO_NUM_EV{1'b0}};
         hrd_q   <= 8'h00;
         for (i = 0; i < `CDIO_NUM_LATCH; i = i + 1)
            lat_src_q[i] <= 8'h00;
      end else if (clk_en && do_wr) begin
         if (aw_addr_q == `CDIO_CTRL_ADDR && w_strb_q[0]) begin
            ctrl_q <= {27'h0, w_data_q[4:0]};
         end else if (aw_addr_q == `CDIO_RESP_ADDR) begin
            for (i = 0; i < 4; i = i + 1)
               if (w_strb_q[i]) resp_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
         end else if (aw_addr_q == `CDIO_IRQ_EN_ADDR && w_strb_q[0]) begin
            ev_en_q <= w_data_q[`CDIO_NUM_EV-1:0];
         end else if (aw_addr_q == `CDIO_HRD_ADDR && w_strb_q[0]) begin
            hrd_q <= w_data_q[7:0];
         end else if (aw_addr_q >= `CDIO_LAT_BASE && aw_addr_q <= `CDIO_LAT_LAST
                      && w_strb_q[0]) begin
            lat_src_q[aw_addr_q[4:2] - 3'h4] <= w_data_q[7:0];
         end
      end
   end

   // display memory: index in bits 3:0, byte in 15:8
   always @(posedge aclk) begin
      if (clk_en && do_wr && aw_addr_q == `CDIO_DISP_ADDR && w_strb_q[1])
         disp_q[w_data_q[3:0]] <= w_data_q[15:8];
   end

   // axi read, one cycle after the address is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `CDIO_RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `CDIO_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr == `CDIO_CTRL_ADDR)
               s_axi_rdata <= ctrl_q;
            else if (s_axi_araddr == `CDIO_RESP_ADDR)
               s_axi_rdata <= resp_q;
            else if (s_axi_araddr == `CDIO_IRQ_STAT_ADDR)
               s_axi_rdata <= {28'h0, ev_stat_q};
            else if (s_axi_araddr == `CDIO_IRQ_CLR_ADDR || s_axi_araddr == `CDIO_DISP_ADDR)
               s_axi_rdata <= 32'h0000_0000;                  // write-only, reads zero
            else if (s_axi_araddr == `CDIO_IRQ_EN_ADDR)
               s_axi_rdata <= {28'h0, ev_en_q};
            else if (s_axi_araddr == `CDIO_STATE_ADDR)
               s_axi_rdata <= {19'h0, activity_indicator, cnt_q, pend_q};
            else if (s_axi_araddr == `CDIO_MTX_LO_ADDR)
               s_axi_rdata <= {mtx_q[3], mtx_q[2], mtx_q[1], mtx_q[0]};
            else if (s_axi_araddr == `CDIO_MTX_HI_ADDR)
               s_axi_rdata <= {mtx_q[7], mtx_q[6], mtx_q[5], mtx_q[4]};
            else if (s_axi_araddr == `CDIO_HWR_ADDR)
               s_axi_rdata <= {24'h0, hwr_q};
            else if (s_axi_araddr == `CDIO_HRD_ADDR)
               s_axi_rdata <= {24'h0, hrd_q};
            else if (s_axi_araddr >= `CDIO_LAT_BASE && s_axi_araddr <= `CDIO_LAT_LAST
                     && s_axi_araddr[1:0] == 2'b00)
               s_axi_rdata <= {24'h0, lat_src_q[s_axi_araddr[4:2] - 3'h4]};
            else
               s_axi_rresp <= `CDIO_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // interrupt status: hardware set wins over a same-cycle clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         ev_stat_q <= {`CDIO_NUM_EV{1'b0}};
         irq       <= 1'b0;
      end else if (clk_en) begin
         if (do_wr && aw_addr_q == `CDIO_IRQ_CLR_ADDR && w_strb_q[0])
            ev_stat_q <= (ev_stat_q & ~w_data_q[`CDIO_NUM_EV-1:0]) | ev_set;
         else
            ev_stat_q <= ev_stat_q | ev_set;
         irq <= |((ev_stat_q | ev_set) & ev_en_q);
      end
   end

   // two-flop synchronisers; a third stage only feeds edge detection
   always @(posedge aclk) begin
      if (!aresetn) begin
         ovl_s1_q <= 8'hff;
         ovl_s2_q <= 8'hff;
         ovl_s3_q <= 8'hff;
         ret_s1_q <= 8'hff;
         ret_s2_q <= 8'hff;
      end else if (clk_en) begin
         ovl_s1_q <= overload_request_n;
         ovl_s2_q <= ovl_s1_q;
         ovl_s3_q <= ovl_s2_q;
         ret_s1_q <= matrix_return_lines;
         ret_s2_q <= ret_s1_q;
      end
   end

   // host transceiver, acknowledge sequencer and interrupt collector
   always @(posedge aclk) begin
      if (!aresetn) begin
         transceiver_enable_n <= 1'b1;
         host_data_o          <= 8'h00;
         host_data_oe_n       <= 8'hff;
         service_request_n    <= 1'b1;
         pend_q               <= 8'h00;
         ack_idx_q            <= 2'b00;
         irq_acknowledge_n_prev_q          <= 1'b1;
         wr_prev_q            <= 1'b1;
         hwr_q                <= 8'h00;
      end else if (clk_en) begin
         transceiver_enable_n <= ~match;
         irq_acknowledge_n_prev_q <= irq_acknowledge_n;
         wr_prev_q   <= host_wr_n;
         // host write lands only when enabled and pointing inward
         if (wr_fall)
            hwr_q <= host_data_i;
         // drive out only when selected, outward, and a strobe asks
         if (sel && !transfer_direction && !irq_acknowledge_n) begin
            host_data_oe_n <= 8'h00;
            if (irq_acknowledge_n_fall)
               host_data_o <= resp_byte;
         end else if (rd_act) begin
            host_data_oe_n <= 8'h00;
            host_data_o    <= hrd_q;
         end else begin
            host_data_oe_n <= 8'hff;
         end
         // step through programmed bytes; last one retires the requests
         if (irq_acknowledge_n_fall) begin
            if (ack_idx_q == resp_last) begin
               ack_idx_q <= 2'b00;
               pend_q    <= ovl_fall;
            end else begin
               ack_idx_q <= ack_idx_q + 2'b01;
               pend_q    <= pend_q | ovl_fall;
            end
         end else begin
            pend_q <= pend_q | ovl_fall;
         end
         service_request_n <= ~|(pend_q | ovl_fall);
      end
   end

   // event sources for the status register
   always @* begin
      ev_set = {`CDIO_NUM_EV{1'b0}};
      ev_set[`CDIO_EV_OVLD]     = |ovl_fall;
      ev_set[`CDIO_EV_ACK_DONE] = irq_acknowledge_n_fall & (ack_idx_q == resp_last);
      ev_set[`CDIO_EV_HOST_WR]  = wr_fall;
      ev_set[`CDIO_EV_MATRIX]   = (mtx_q[idx_p2_q] != ~ret_s2_q);
   end

   // scan counter, decoder, display nibbles and latch strobes
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q             <= 4'h0;
         scan_select_lines <= 4'h0;
         scan_lines_n      <= 8'hff;
         display_nibble_a  <= 4'h0;
         display_nibble_b  <= 4'h0;
         latch_strobe_n    <= 5'h1f;
         idx_p1_q          <= 3'h0;
         idx_p2_q          <= 3'h0;
      end else if (clk_en) begin
         cnt_q             <= cnt_d;
         scan_select_lines <= cnt_d;
         scan_lines_n      <= ctrl_q[`CDIO_CTRL_DEC_EN]
                              ? ~(8'h01 << cnt_d[2:0]) : 8'hff;
         display_nibble_a  <= disp_q[cnt_d][3:0];
         display_nibble_b  <= disp_q[cnt_d][7:4];
         for (i = 0; i < `CDIO_NUM_LATCH; i = i + 1)
            latch_strobe_n[i] <= (cnt_d != i);
         // index follows the returns through the synchroniser delay
         idx_p1_q <= scan_select_lines[2:0];
         idx_p2_q <= idx_p1_q;
      end
   end

   // matrix image, one bit set per closed point (return line low)
   always @(posedge aclk) begin
      if (!aresetn) begin
         for (i = 0; i < 8; i = i + 1)
            mtx_q[i] <= 8'h00;
      end else if (clk_en && ctrl_q[`CDIO_CTRL_DEC_EN]) begin
         mtx_q[idx_p2_q] <= ~ret_s2_q;
      end
   end

   // latched drivers capture on the strobe's falling edge, clear high
   always @(posedge aclk) begin
      if (!aresetn) begin
         driver_oe_n <= {40{1'b1}};
      end else if (clk_en) begin
         for (i = 0; i < `CDIO_NUM_LATCH; i = i + 1)
            if (latch_strobe_n[i] && cnt_d == i && ctrl_q[`CDIO_CTRL_LAT_CLR])
               driver_oe_n[i*8 +: 8] <= ~lat_src_q[i];
            else if (!ctrl_q[`CDIO_CTRL_LAT_CLR])
               driver_oe_n[i*8 +: 8] <= 8'hff;
      end
   end

   // retriggerable monitor; a wide counter keeps the led steady between pulses
   always @(posedge aclk) begin
      if (!aresetn) begin
         act_cnt_q          <= 24'h000000;
         activity_indicator <= 1'b0;
      end else if (clk_en) begin
         if (trig && !ctrl_q[`CDIO_CTRL_INHIBIT])
            act_cnt_q <= ACT_LOAD;
         else if (act_cnt_q != 24'h000000)
            act_cnt_q <= act_cnt_q - 24'h000001;
         activity_indicator <= (trig && !ctrl_q[`CDIO_CTRL_INHIBIT])
                               || (act_cnt_q > 24'h000001);
      end
   end
endmodule // cdio_board
`default_nettype wire

// File: verification/cdio_board_sva.sv
/*
 * checker for cdio_board: scan counter, decoder, strobes, board select,
 * host drive, axi holds and overload request timing.
 * assumes it sees only the top ports, attached by the bind at the foot.
 */
`timescale 1ns/1ps
`default_nettype none
module cdio_board_sva #(
   parameter ACT_CYCLES = 20
) (
   input wire logic        aclk,                 // clock
   input wire logic        aresetn,              // sync reset, low
   input wire logic        clk_en,               // run enable
   input wire logic        s_axi_bvalid,         // write response valid
   input wire logic        s_axi_bready,         // write response ready
   input wire logic        s_axi_rvalid,         // read data valid
   input wire logic        s_axi_rready,         // read data ready
   input wire logic [31:0] s_axi_rdata,          // read data
   input wire logic [3:0]  host_addr,            // host address
   input wire logic [3:0]  board_id_jumpers,     // jumper id
   input wire logic        transfer_direction,   // host direction
   input wire logic [7:0]  host_data_oe_n,       // host drive enables
   input wire logic        transceiver_enable_n, // board selected, low
   input wire logic        service_request_n,    // service wanted, low
   input wire logic [7:0]  overload_request_n,   // overload inputs
   input wire logic [3:0]  scan_select_lines,    // scan count
   input wire logic [7:0]  scan_lines_n,         // decoded scan lines
   input wire logic [4:0]  latch_strobe_n        // latch strobes
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // counter steps on every enabled edge, wrapping at fifteen
   a_scan_count:
      assert property ($past(clk_en) && $past(aresetn) |->
         scan_select_lines == $past(scan_select_lines) + 4'h1) else $error("scan count step");
   // only the line of the current position may be low
   a_scan_decode:
      assert property (scan_lines_n != 8'hff |->
         scan_lines_n == ~(8'h01 << scan_select_lines[2:0])) else $error("scan decode");
   // strobe k low exactly at count k, none past the last latch
   a_strobe_decode:
      assert property ($past(aresetn) |-> latch_strobe_n == ((scan_select_lines < 4'h5) ?
         ~(5'h01 << scan_select_lines[2:0]) : 5'h1f)) else $error("strobe decode");
   // select follows the address compare one edge later
   a_board_match:
      assert property ($past(clk_en) && $past(aresetn) |-> transceiver_enable_n ==
         ($past(host_addr) != $past(board_id_jumpers))) else $error("board match");
   // driving the host needs select and outbound direction first
   a_drive_gate:
      assert property (host_data_oe_n != 8'hff |-> host_data_oe_n == 8'h00 &&
         !$past(transceiver_enable_n) && !$past(transfer_direction)) else $error("drive gate");
   a_bvalid_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid drop");
   a_rvalid_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
         else $error("rvalid drop");
   // sync delay plus the service request flop, so a fixed short bound
   a_overload_req:
      assert property (|($past(overload_request_n) & ~overload_request_n) |->
         ##[1:6] !service_request_n) else $error("overload not signalled");
endmodule // cdio_board_sva
`default_nettype wire

bind cdio_board cdio_board_sva #(.ACT_CYCLES(ACT_CYCLES)) u_sva (.aclk, .aresetn, .clk_en,
   .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .host_addr,
   .board_id_jumpers, .transfer_direction, .host_data_oe_n, .transceiver_enable_n,
   .service_request_n, .overload_request_n, .scan_select_lines, .scan_lines_n,
   .latch_strobe_n);

// File: verification/cdio_matrix_model.sv
/*
 * status matrix partner: a closed point sinks its return line while
 * its position is scanned. assumes pull-ups on every return line.
 */
`timescale 1ns/1ps
`default_nettype none
module cdio_matrix_model (
   input  wire logic [7:0]  scan_lines_n,        // scan lines, low
   input  wire logic [63:0] closed_map,          // byte k = position k
   output var  logic [7:0]  matrix_return_lines  // return lines
);
   // pulled up when idle, so no stale level survives a scan step
   always_comb begin
      matrix_return_lines = 8'hff;
      for (int k = 0; k < 8; k++)
         if (!scan_lines_n[k])
            matrix_return_lines &= ~closed_map[8*k +: 8];
   end
endmodule // cdio_matrix_model
`default_nettype wire

// File: verification/cdio_board_tb.sv
/*
 * bench for cdio_board: axi4-lite register tasks, host bus strobes,
 * overload lines and the matrix partner. assumes defines on the path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cdio_defines.vh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; \
   $display("unexpected %s exp %h got %h", n, e, s); end end
module cdio_board_tb;
   localparam [3:0] ID = 4'ha;
   logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, hdir = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        irq_acknowledge_n_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, hdi = 8'h00, ovl_n = 8'hff, hdo, hoe_n;
   logic [7:0]  scan_n, ret;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [63:0] closed = 64'h0;
   logic [3:0]  haddr = 4'h0, sel, s0, nib_a, nib_b;
   logic [1:0]  bresp, rresp, r;
   logic [4:0]  strb_n;
   logic [39:0] drv_n;
   logic        awready, wready, bvalid, arready, rvalid, irq, ten_n, srq_n, act;
   int          err_count = 0, comparisons = 0, k;

   always #5 aclk = ~aclk;
   cdio_matrix_model u_mtx (.scan_lines_n(scan_n), .closed_map(closed),
      .matrix_return_lines(ret));
   cdio_board #(.ACT_CYCLES(20)) DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq(irq), .host_addr(haddr), .board_id_jumpers(ID),
      .transfer_direction(hdir), .irq_acknowledge_n(irq_acknowledge_n_n), .host_wr_n(wr_n),
      .host_rd_n(rd_n), .host_data_i(hdi), .host_data_o(hdo), .host_data_oe_n(hoe_n),
      .transceiver_enable_n(ten_n), .service_request_n(srq_n), .overload_request_n(ovl_n),
      .scan_select_lines(sel), .scan_lines_n(scan_n), .matrix_return_lines(ret),
      .display_nibble_a(nib_a), .display_nibble_b(nib_b), .latch_strobe_n(strb_n),
      .driver_oe_n(drv_n), .activity_indicator(act));

   // write: each channel released at its own handshake edge
   task wr(input [7:0] a, input [31:0] v);
      bit pa, pw;
      begin
         pa = 1'b1;
         pw = 1'b1;
         @(posedge aclk);
         awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
         while (pa || pw) begin
            @(posedge aclk);
            if (awready) pa = 1'b0;
            if (wready) pw = 1'b0;
            awvalid <= pa;
            wvalid <= pw;
         end
         while (!bvalid) @(posedge aclk);
         r = bresp;
         bready <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge aclk);
         araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
         @(posedge aclk);
         while (!arready) @(posedge aclk);
         arvalid <= 1'b0;
         while (!rvalid) @(posedge aclk);
         d = rdata;
         r = rresp;
         rready <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task rchk(input [7:0] a, input [31:0] m, input [31:0] e);
      begin
         rd(a);
         `CHK("register", e, d & m)
      end
   endtask
   // strobe s: bit0 acknowledge, bit1 write, bit2 read; ends mid-cycle
   task host(input [2:0] s, input dir);
      begin
         hdir <= dir;
         @(posedge aclk);
         {rd_n, wr_n, irq_acknowledge_n_n} <= ~s;
         repeat (3) @(negedge aclk);
      end
   endtask
   task hrel;
      begin
         @(posedge aclk);
         {rd_n, wr_n, irq_acknowledge_n_n} <= 3'b111;
         repeat (2) @(posedge aclk);
      end
   endtask
   task summarize;
      begin
         $display("err_count %0d comparisons %0d", err_count, comparisons);
         if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask

   initial begin
      repeat (3) @(posedge aclk);
      `CHK("reset drive", 8'hff, hoe_n)
      `CHK("reset strobes", 5'h1f, strb_n)
      aresetn <= 1'b1;
      @(posedge aclk);
      rchk(`CDIO_CTRL_ADDR, 32'hffffffff, `CDIO_CTRL_RESET);
      rd(8'hfc);
      `CHK("unmapped resp", `CDIO_RESP_SLVERR, r)
      // overload then the four-byte acknowledge walk
      wr(`CDIO_RESP_ADDR, 32'h44332211);
      `CHK("write resp", `CDIO_RESP_OKAY, r)
      wr(`CDIO_IRQ_EN_ADDR, 32'h1);
      haddr <= ID;
      ovl_n <= 8'hfb;
      repeat (8) @(negedge aclk);
      `CHK("service", 1'b0, srq_n)
      `CHK("irq", 1'b1, irq)
      rchk(`CDIO_STATE_ADDR, 32'hff, 32'h04);
      wr(`CDIO_IRQ_EN_ADDR, 32'h0);
      repeat (2) @(negedge aclk);
      `CHK("masked irq", 1'b0, irq)
      wr(`CDIO_IRQ_EN_ADDR, 32'h1);
      for (k = 0; k < 4; k++) begin
         host(3'b001, 1'b0);
         `CHK("ack drive", 8'h00, hoe_n)
         `CHK("ack byte", 8'(8'h11 * (k + 1)), hdo)
         hrel;
      end
      `CHK("service done", 1'b1, srq_n)
      rchk(`CDIO_IRQ_STAT_ADDR, 32'h3, 32'h3);
      wr(`CDIO_IRQ_CLR_ADDR, 32'h3);
      rchk(`CDIO_IRQ_STAT_ADDR, 32'h3, 32'h0);
      `CHK("irq cleared", 1'b0, irq)
      ovl_n <= 8'hff;
      // host write inbound, host read outbound, then an unselected read
      hdi <= 8'ha5;
      host(3'b010, 1'b1);
      `CHK("inbound drive", 8'hff, hoe_n)
      hrel;
      rchk(`CDIO_HWR_ADDR, 32'hff, 32'ha5);
      wr(`CDIO_HRD_ADDR, 32'h5a);
      host(3'b100, 1'b0);
      `CHK("read data", 8'h5a, hdo)
      `CHK("activity on", 1'b1, act)
      hrel;
      haddr <= ~ID;
      host(3'b100, 1'b0);
      `CHK("unselected", 1'b1, ten_n)
      `CHK("unselected drive", 8'hff, hoe_n)
      hrel;
      repeat (40) @(negedge aclk);
      `CHK("activity off", 1'b0, act)
      // latch one, then clear drops every driver
      wr(`CDIO_LAT_BASE + 8'h04, 32'h81);
      repeat (20) @(negedge aclk);
      `CHK("driver one", 16'h7eff, drv_n[15:0])
      wr(`CDIO_CTRL_ADDR, 32'h19);
      repeat (20) @(negedge aclk);
      `CHK("cleared drivers", {40{1'b1}}, drv_n)
      wr(`CDIO_CTRL_ADDR, `CDIO_CTRL_RESET);
      closed <= 64'h0020_0000;
      repeat (40) @(posedge aclk);
      rchk(`CDIO_MTX_LO_ADDR, 32'hffffffff, 32'h0020_0000);
      // frozen count, then stepping and display alignment
      clk_en <= 1'b0;
      @(negedge aclk);
      s0 = sel;
      repeat (3) @(negedge aclk);
      `CHK("frozen", s0, sel)
      @(posedge aclk);
      clk_en <= 1'b1;
      wr(`CDIO_DISP_ADDR, 32'h0000_c703);
      @(negedge aclk);
      s0 = sel;
      @(negedge aclk);
      `CHK("count step", 4'(s0 + 4'h1), sel)
      repeat (16) begin
         @(negedge aclk);
         if (sel === 4'h3)
            `CHK("display", 8'hc7, {nib_b, nib_a})
      end
      summarize;
   end
   // whole run is well under a thousand cycles
   initial begin
      #200000;
      err_count++;
      summarize;
   end
endmodule // cdio_board_tb
`default_nettype wire
